// ### gbi_map.svh
// Constants for the bus interface: codes, bit positions and timing
`ifndef GBI_MAP_SVH
`define GBI_MAP_SVH
`define GBI_CLK_MHZ 40
`define GBI_SETTLE_NS 2000
`define GBI_SETTLE_CYC ((`GBI_SETTLE_NS * `GBI_CLK_MHZ + 999) / 1000)
`define GBI_LOCAL_US 100
`define GBI_LOCAL_CYC (`GBI_LOCAL_US * `GBI_CLK_MHZ)
`define GBI_RQS_BIT 6
`define GBI_CMD_DCL 8'h14
`define GBI_CMD_LLO 8'h11
`define GBI_CMD_PPU 8'h15
`define GBI_CMD_GTL 8'h01
`define GBI_CMD_SPE 8'h18
`define GBI_CMD_SPD 8'h19
`define GBI_CMD_UNL 8'h3F
`define GBI_CMD_UNT 8'h5F
`define GBI_GRP_LSN 2'b01
`define GBI_GRP_TLK 2'b10
`endif

// ### gbi_pkg.sv
// Types shared by the bus interface modules
package gbi_pkg;
	typedef enum logic [1:0] {
		GBI_SH_IDLE = 2'b00,
		GBI_SH_SETTLE = 2'b01,
		GBI_SH_VALID = 2'b10
	} gbi_sh_t;
	typedef enum logic [1:0] {
		GBI_AH_READY = 2'b00,
		GBI_AH_ACCEPT = 2'b01,
		GBI_AH_WAIT = 2'b10
	} gbi_ah_t;
endpackage

// ### gbi_sync_if.sv
// Synchronised bus control levels passed from the sampler to the core
`timescale 1ns/1ps
interface gbi_sync_if;
	logic atn;
	logic ifc;
	logic ren;
	logic eoi;
	logic dav;
	logic nrfd;
	logic ndac;
	logic [7:0] dio;
	modport src (output atn, ifc, ren, eoi, dav, nrfd, ndac, dio);
	modport dst (input atn, ifc, ren, eoi, dav, nrfd, ndac, dio);
endinterface // gbi_sync_if

// ### gbi_sync.sv
// Two-stage synchronisers for all bus lines except SRQ, true-active outputs
`timescale 1ns/1ps
module gbi_sync (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] dio_n_i,
	input wire logic atn_n_i,
	input wire logic ifc_n_i,
	input wire logic ren_n_i,
	input wire logic eoi_n_i,
	input wire logic dav_n_i,
	input wire logic nrfd_n_i,
	input wire logic ndac_n_i,
	gbi_sync_if.src s
);
	localparam int W = 15;
	logic [W-1:0] raw;
	logic [W-1:0] st1_r;
	logic [W-1:0] st2_r;
	// Inverted so the core sees asserted as 1
	assign raw = ~{dio_n_i, atn_n_i, ifc_n_i, ren_n_i, eoi_n_i, dav_n_i, nrfd_n_i, ndac_n_i};
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					st1_r[i] <= 1'b0;
					st2_r[i] <= 1'b0;
				end else begin
					st1_r[i] <= raw[i];
					st2_r[i] <= st1_r[i];
				end
			end
		end
	endgenerate
	assign {s.dio, s.atn, s.ifc, s.ren, s.eoi, s.dav, s.nrfd, s.ndac} = st2_r;
endmodule // gbi_sync

// ### gbi_core.sv
// Instrument-side bus interface: handshakes, addressing, SRQ, remote/local
`timescale 1ns/1ps
`include "gbi_map.svh"
module gbi_core #(
	parameter int LOCAL_CYC = `GBI_LOCAL_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [4:0] my_addr,
	input wire logic [7:0] dio_n_i,
	output logic [7:0] dio_n_o,
	output logic [7:0] dio_n_oe,
	input wire logic atn_n_i,
	input wire logic ifc_n_i,
	input wire logic ren_n_i,
	input wire logic eoi_n_i,
	output logic eoi_n_o,
	output logic eoi_n_oe,
	input wire logic dav_n_i,
	output logic dav_n_o,
	output logic dav_n_oe,
	input wire logic nrfd_n_i,
	output logic nrfd_n_o,
	output logic nrfd_n_oe,
	input wire logic ndac_n_i,
	output logic ndac_n_o,
	output logic ndac_n_oe,
	output logic srq_n_o,
	output logic srq_n_oe,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data_r,
	output logic rx_last_r,
	output logic cmd_valid_r,
	output logic [7:0] cmd_data_r,
	output logic ppoll_r,
	input wire logic svc_req,
	input wire logic [7:0] status_byte,
	input wire logic local_sw,
	output logic talker_r,
	output logic listener_r,
	output logic remote_r,
	output logic lockout_r,
	output logic dev_clear_r
);
	localparam int SETTLE = `GBI_SETTLE_CYC;
	gbi_sync_if sy ();
	gbi_sync u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.dio_n_i(dio_n_i),
		.atn_n_i(atn_n_i),
		.ifc_n_i(ifc_n_i),
		.ren_n_i(ren_n_i),
		.eoi_n_i(eoi_n_i),
		.dav_n_i(dav_n_i),
		.nrfd_n_i(nrfd_n_i),
		.ndac_n_i(ndac_n_i),
		.s(sy.src)
	);

	gbi_pkg::gbi_sh_t sh_r;
	gbi_pkg::gbi_ah_t ah_r;
	logic [7:0] txd_r;
	logic txe_r;
	logic [7:0] set_cnt_r;
	logic spoll_r;
	logic rsv_r;
	logic [$clog2(LOCAL_CYC+1)-1:0] loc_cnt_r;
	logic rx_pend_r;
	logic ah_en;
	logic take;
	logic is_cmd;
	logic [7:0] b;

	// Acceptor enabled under ATN for commands, else only as listener
	assign ah_en = sy.atn | listener_r;
	assign b = sy.dio;
	assign take = (ah_r == gbi_pkg::GBI_AH_ACCEPT);
	assign is_cmd = take & sy.atn;

	// Acceptor handshake: while enabled, NRFD released only while NDAC held low
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ah_r <= gbi_pkg::GBI_AH_READY;
		end else if (!ah_en) begin
			ah_r <= gbi_pkg::GBI_AH_READY;
		end else begin
			case (ah_r)
				gbi_pkg::GBI_AH_READY: begin
					if (sy.dav && (sy.atn || !rx_pend_r)) begin
						ah_r <= gbi_pkg::GBI_AH_ACCEPT;
					end
				end
				gbi_pkg::GBI_AH_ACCEPT: ah_r <= gbi_pkg::GBI_AH_WAIT;
				gbi_pkg::GBI_AH_WAIT: begin
					if (!sy.dav) begin
						ah_r <= gbi_pkg::GBI_AH_READY;
					end
				end
				default: ah_r <= gbi_pkg::GBI_AH_READY;
			endcase
		end
	end
	// Not ready while a byte is held or, without ATN, while a data byte is still unread
	assign nrfd_n_oe = ah_en & ((ah_r != gbi_pkg::GBI_AH_READY) | (!sy.atn & rx_pend_r));
	assign nrfd_n_o = 1'b0;
	assign ndac_n_oe = ah_en & (ah_r != gbi_pkg::GBI_AH_WAIT);
	assign ndac_n_o = 1'b0;

	// Received data with end flag
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_pend_r <= 1'b0;
			rx_data_r <= 8'h00;
			rx_last_r <= 1'b0;
		end else if (take && !sy.atn) begin
			rx_pend_r <= 1'b1;
			rx_data_r <= b;
			rx_last_r <= sy.eoi;
		end else if (rx_ready) begin
			rx_pend_r <= 1'b0;
		end
	end
	assign rx_valid = rx_pend_r;

	// Command strobe out; parallel poll indication
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_valid_r <= 1'b0;
			cmd_data_r <= 8'h00;
			ppoll_r <= 1'b0;
		end else begin
			cmd_valid_r <= is_cmd && !sy.ifc;
			cmd_data_r <= is_cmd ? b : cmd_data_r;
			ppoll_r <= sy.atn & sy.eoi;
		end
	end

	// Addressing; IFC clears it and blocks addressed commands
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			talker_r <= 1'b0;
			listener_r <= 1'b0;
			spoll_r <= 1'b0;
		end else if (sy.ifc) begin
			talker_r <= 1'b0;
			listener_r <= 1'b0;
			spoll_r <= 1'b0;
		end else if (is_cmd) begin
			if (b[6:5] == `GBI_GRP_TLK) begin
				talker_r <= (b[4:0] == my_addr) && (b[4:0] != 5'h1F);
			end
			if (b[6:5] == `GBI_GRP_LSN && b[4:0] == my_addr) begin
				listener_r <= 1'b1;
			end
			if (b[6:0] == 7'(`GBI_CMD_UNL)) begin
				listener_r <= 1'b0;
			end
			if (b[6:0] == 7'(`GBI_CMD_SPE)) begin
				spoll_r <= 1'b1;
			end
			if (b[6:0] == 7'(`GBI_CMD_SPD)) begin
				spoll_r <= 1'b0;
			end
		end
	end

	// Universal commands DCL and LLO also honoured during IFC; SPE and SPD are not
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			remote_r <= 1'b0;
			lockout_r <= 1'b0;
			dev_clear_r <= 1'b0;
			loc_cnt_r <= '0;
		end else begin
			dev_clear_r <= is_cmd && (b[6:0] == 7'(`GBI_CMD_DCL));
			if (!sy.ren) begin
				remote_r <= 1'b0;
				lockout_r <= 1'b0;
			end else begin
				if (is_cmd && b[6:0] == 7'(`GBI_CMD_LLO)) begin
					lockout_r <= 1'b1;
				end
				if (is_cmd && !sy.ifc && b[6:5] == `GBI_GRP_LSN && b[4:0] == my_addr) begin
					remote_r <= 1'b1;
				end else if (is_cmd && !sy.ifc && listener_r && b[6:0] == 7'(`GBI_CMD_GTL)) begin
					remote_r <= 1'b0;
				end else if (local_sw && !lockout_r) begin
					remote_r <= 1'b0;
				end
			end
			loc_cnt_r <= (sy.ren || !remote_r) ? '0 : loc_cnt_r + 1'b1;
		end
	end

	// Service request held until polled status read
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rsv_r <= 1'b0;
		end else if (svc_req) begin
			rsv_r <= 1'b1;
		end else if (spoll_r && talker_r && sh_r == gbi_pkg::GBI_SH_VALID && sy.ndac) begin
			rsv_r <= 1'b0;
		end
	end
	assign srq_n_o = 1'b0;
	assign srq_n_oe = rsv_r & !(spoll_r & talker_r & sh_r == gbi_pkg::GBI_SH_VALID);

	// Source handshake, active only when talking without ATN
	assign tx_ready = (sh_r == gbi_pkg::GBI_SH_IDLE) & talker_r & !sy.atn & !spoll_r;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sh_r <= gbi_pkg::GBI_SH_IDLE;
			txd_r <= 8'h00;
			txe_r <= 1'b0;
			set_cnt_r <= 8'h00;
		end else if (sy.atn || !talker_r) begin
			sh_r <= gbi_pkg::GBI_SH_IDLE;
		end else begin
			case (sh_r)
				gbi_pkg::GBI_SH_IDLE: begin
					set_cnt_r <= 8'h00;
					if (spoll_r) begin
						txd_r <= status_byte;
						txd_r[`GBI_RQS_BIT] <= rsv_r;
						txe_r <= 1'b0;
						sh_r <= gbi_pkg::GBI_SH_SETTLE;
					end else if (tx_valid) begin
						txd_r <= tx_data;
						txe_r <= tx_last;
						sh_r <= gbi_pkg::GBI_SH_SETTLE;
					end
				end
				gbi_pkg::GBI_SH_SETTLE: begin
					if (sy.nrfd) begin
						set_cnt_r <= 8'h00;
					end else if (set_cnt_r >= 8'(SETTLE - 1)) begin
						sh_r <= gbi_pkg::GBI_SH_VALID;
					end else begin
						set_cnt_r <= set_cnt_r + 8'h01;
					end
				end
				gbi_pkg::GBI_SH_VALID: begin
					if (!sy.ndac) begin
						sh_r <= gbi_pkg::GBI_SH_VALID;
					end else if (!spoll_r) begin
						sh_r <= gbi_pkg::GBI_SH_IDLE;
					end else begin
						sh_r <= gbi_pkg::GBI_SH_IDLE;
					end
				end
				default: sh_r <= gbi_pkg::GBI_SH_IDLE;
			endcase
		end
	end
	assign dio_n_o = ~txd_r;
	assign dio_n_oe = {8{sh_r != gbi_pkg::GBI_SH_IDLE}};
	assign eoi_n_o = 1'b0;
	assign eoi_n_oe = (sh_r != gbi_pkg::GBI_SH_IDLE) & txe_r;
	assign dav_n_o = 1'b0;
	assign dav_n_oe = (sh_r == gbi_pkg::GBI_SH_VALID);

	property p_no_both_released;
		@(posedge mclk) disable iff (!rst_n) ah_en |-> (nrfd_n_oe | ndac_n_oe);
	endproperty
	a_no_both_released: assert property (p_no_both_released) else $error("NRFD and NDAC released");
	property p_dav_after_ready;
		@(posedge mclk) disable iff (!rst_n) $rose(dav_n_oe) |-> $past(!sy.nrfd, 1);
	endproperty
	a_dav_after_ready: assert property (p_dav_after_ready) else $error("DAV while NRFD asserted");
	property p_data_before_dav;
		@(posedge mclk) disable iff (!rst_n) $rose(dav_n_oe) |-> $past(dio_n_oe[0], 2);
	endproperty
	a_data_before_dav: assert property (p_data_before_dav) else $error("DAV before data");
	property p_settle;
		@(posedge mclk) disable iff (!rst_n) $rose(dav_n_oe) |-> $past(set_cnt_r, 1) == 8'(SETTLE - 1);
	endproperty
	a_settle: assert property (p_settle) else $error("DAV before settle time");
	property p_ifc_clear;
		@(posedge mclk) disable iff (!rst_n) sy.ifc |=> !talker_r && !listener_r;
	endproperty
	a_ifc_clear: assert property (p_ifc_clear) else $error("Addressing survived IFC");
	property p_local;
		@(posedge mclk) disable iff (!rst_n) !sy.ren |=> !remote_r;
	endproperty
	a_local: assert property (p_local) else $error("Remote without REN");
	property p_srq_hold;
		@(posedge mclk) disable iff (!rst_n) rsv_r && !spoll_r |-> srq_n_oe;
	endproperty
	a_srq_hold: assert property (p_srq_hold) else $error("SRQ dropped before poll");
	property p_no_talk_atn;
		@(posedge mclk) disable iff (!rst_n) sy.atn |=> !dav_n_oe && !dio_n_oe[0];
	endproperty
	a_no_talk_atn: assert property (p_no_talk_atn) else $error("Talking under ATN");
endmodule // gbi_core

// ### gbi_ctl.sv
// Behavioural controller and far-end bus instrument
`timescale 1ns/1ps
module gbi_ctl (
	input wire logic mclk,
	input wire logic [7:0] dio_n,
	input wire logic dav_n,
	input wire logic nrfd_n,
	input wire logic ndac_n,
	input wire logic eoi_n,
	output logic [7:0] d_n_r,
	output logic atn_n_r,
	output logic ifc_n_r,
	output logic ren_n_r,
	output logic eoi_n_r,
	output logic dav_n_r,
	output logic nrfd_n_r,
	output logic ndac_n_r
);
	initial begin
		{d_n_r, atn_n_r, ifc_n_r, ren_n_r, eoi_n_r, dav_n_r, nrfd_n_r, ndac_n_r} = '1;
	end
	task automatic mgmt(input logic atn, input logic eoi, input logic ifc, input logic ren);
		atn_n_r <= ~atn;
		eoi_n_r <= ~eoi;
		ifc_n_r <= ~ifc;
		ren_n_r <= ~ren;
		@(posedge mclk);
	endtask
	// Source side; released lines float to the pull-up level
	task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
		atn_n_r <= ~atn;
		nrfd_n_r <= 1'b1;
		ndac_n_r <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 400 && (nrfd_n !== 1'b1 || ndac_n !== 1'b0); i++) @(posedge mclk);
		d_n_r <= ~b;
		eoi_n_r <= ~eoi;
		repeat (81) @(posedge mclk);
		dav_n_r <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 400 && ndac_n !== 1'b1; i++) @(posedge mclk);
		{dav_n_r, eoi_n_r, d_n_r} <= '1;
		@(posedge mclk);
	endtask
	// Acceptor side; NRFD pulled before NDAC is let go, never both high
	task automatic recv(output logic [7:0] b, output logic eoi, output int w);
		atn_n_r <= 1'b1;
		ndac_n_r <= 1'b0;
		@(posedge mclk);
		nrfd_n_r <= 1'b1;
		w = 0;
		for (int i = 0; i < 400 && dav_n !== 1'b0; i++) begin
			@(posedge mclk);
			w++;
		end
		b = ~dio_n;
		eoi = ~eoi_n;
		nrfd_n_r <= 1'b0;
		@(posedge mclk);
		ndac_n_r <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 400 && dav_n !== 1'b1; i++) @(posedge mclk);
		ndac_n_r <= 1'b0;
		@(posedge mclk);
	endtask
endmodule // gbi_ctl

// ### tb.sv
// Self-checking bench for the bus interface core
`timescale 1ns/1ps
`include "gbi_map.svh"
module tb;
	logic mclk = 0;
	logic rst_n = 0;
	logic tx_valid = 0;
	logic tx_last = 0;
	logic rx_ready = 0;
	logic svc_req = 0;
	logic local_sw = 0;
	wire logic [7:0] cmd_data_r;
	logic [7:0] tx_data = 8'h00;
	int n_fail = 0;
	int tests_run = 0;
	int n_dcl = 0;
	int cyc = 0;
	wire logic [7:0] dio_n, d_n, dio_n_o, dio_n_oe, rx_data_r;
	wire logic atn_n, ifc_n, ren_n, eoi_n, dav_n, nrfd_n, ndac_n, c_eoi, c_dav, c_nrfd, c_ndac;
	wire logic eoi_oe, dav_oe, nrfd_oe, ndac_oe, srq_oe, tx_ready, rx_valid, rx_last_r, ppoll_r;
	wire logic talker_r, listener_r, remote_r, lockout_r, dev_clear_r;
	// Wired-AND of both parties on the DIO, EOI, DAV, NRFD and NDAC lines; SRQ is not modelled
	assign dio_n = (dio_n_o | ~dio_n_oe) & d_n;
	assign eoi_n = ~eoi_oe & c_eoi;
	assign dav_n = ~dav_oe & c_dav;
	assign nrfd_n = ~nrfd_oe & c_nrfd;
	assign ndac_n = ~ndac_oe & c_ndac;
	gbi_core dut_u (.mclk(mclk), .rst_n(rst_n), .my_addr(5'h0c), .dio_n_i(dio_n),
		.dio_n_o(dio_n_o), .dio_n_oe(dio_n_oe), .atn_n_i(atn_n), .ifc_n_i(ifc_n),
		.ren_n_i(ren_n), .eoi_n_i(eoi_n), .eoi_n_o(), .eoi_n_oe(eoi_oe), .dav_n_i(dav_n),
		.dav_n_o(), .dav_n_oe(dav_oe), .nrfd_n_i(nrfd_n), .nrfd_n_o(), .nrfd_n_oe(nrfd_oe),
		.ndac_n_i(ndac_n), .ndac_n_o(), .ndac_n_oe(ndac_oe), .srq_n_o(), .srq_n_oe(srq_oe),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data_r(rx_data_r),
		.rx_last_r(rx_last_r), .cmd_valid_r(), .cmd_data_r(cmd_data_r), .ppoll_r(ppoll_r),
		.svc_req(svc_req), .status_byte(8'h05), .local_sw(local_sw), .talker_r(talker_r),
		.listener_r(listener_r), .remote_r(remote_r), .lockout_r(lockout_r),
		.dev_clear_r(dev_clear_r));
	gbi_ctl ctl_u (.mclk(mclk), .dio_n(dio_n), .dav_n(dav_n), .nrfd_n(nrfd_n),
		.ndac_n(ndac_n), .eoi_n(eoi_n), .d_n_r(d_n), .atn_n_r(atn_n), .ifc_n_r(ifc_n),
		.ren_n_r(ren_n), .eoi_n_r(c_eoi), .dav_n_r(c_dav), .nrfd_n_r(c_nrfd),
		.ndac_n_r(c_ndac));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (dev_clear_r === 1'b1) n_dcl++;
		if (listener_r === 1'b1 && nrfd_n === 1'b1 && ndac_n === 1'b1) check(0, 1);
		if (cyc == 40000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic t_listen();
		ctl_u.mgmt(1, 0, 0, 1);
		ctl_u.send(8'h2c, 1, 0);
		ctl_u.send(`GBI_CMD_LLO, 1, 0);
		check({listener_r, remote_r, lockout_r}, 3'b111);
		check(cmd_data_r, `GBI_CMD_LLO);
		// Front-panel return is locked out, so remote must hold
		local_sw <= 1;
		repeat (4) @(posedge mclk);
		check(remote_r, 1);
		local_sw <= 0;
		ctl_u.send(8'h41, 0, 0);
		repeat (10) @(posedge mclk);
		// Consumer stalls, so the next byte must wait behind NRFD
		check({rx_valid, nrfd_oe, rx_data_r, rx_last_r}, {2'b11, 8'h41, 1'b0});
		rx_ready <= 1;
		@(posedge mclk);
		rx_ready <= 0;
		ctl_u.send(8'h42, 0, 1);
		repeat (10) @(posedge mclk);
		check({rx_valid, rx_data_r, rx_last_r}, {1'b1, 8'h42, 1'b1});
		rx_ready <= 1;
		@(posedge mclk);
		rx_ready <= 0;
		ctl_u.send(`GBI_CMD_UNL, 1, 0);
		check(listener_r, 0);
		ctl_u.mgmt(1, 0, 0, 0);
		repeat (5) @(posedge mclk);
		check(remote_r, 0);
	endtask
	task automatic t_talk();
		logic [7:0] b [2];
		logic e [2];
		int w [2];
		ctl_u.send(8'h4c, 1, 0);
		check(talker_r, 1);
		fork
			begin
				for (int k = 0; k < 2; k++) begin
					tx_valid <= 1;
					tx_data <= k ? 8'h62 : 8'h61;
					tx_last <= k[0];
					@(negedge mclk);
					for (int i = 0; i < 400 && tx_ready !== 1'b1; i++) @(negedge mclk);
					@(posedge mclk);
				end
				tx_valid <= 0;
			end
			for (int k = 0; k < 2; k++) ctl_u.recv(b[k], e[k], w[k]);
		join
		check({b[0], b[1]}, 16'h6162);
		check({e[0], e[1]}, 2'b01);
		check(w[0] >= `GBI_SETTLE_CYC && w[1] >= `GBI_SETTLE_CYC, 1);
		ctl_u.send(`GBI_CMD_UNT, 1, 0);
		check(talker_r, 0);
	endtask
	task automatic t_poll();
		logic [7:0] b;
		logic e;
		int w;
		svc_req <= 1;
		@(posedge mclk);
		svc_req <= 0;
		repeat (2) @(posedge mclk);
		check(srq_oe, 1);
		ctl_u.send(`GBI_CMD_SPE, 1, 0);
		ctl_u.send(8'h4c, 1, 0);
		ctl_u.recv(b, e, w);
		check({b, e}, {8'h45, 1'b0});
		repeat (4) @(posedge mclk);
		check(srq_oe, 0);
		ctl_u.send(`GBI_CMD_SPD, 1, 0);
		ctl_u.send(`GBI_CMD_UNT, 1, 0);
		ctl_u.mgmt(1, 1, 0, 0);
		repeat (4) @(posedge mclk);
		check(ppoll_r, 1);
		ctl_u.mgmt(1, 0, 0, 0);
	endtask
	task automatic t_ifc();
		ctl_u.send(8'h4c, 1, 0);
		ctl_u.mgmt(1, 0, 1, 0);
		ctl_u.send(`GBI_CMD_DCL, 1, 0);
		ctl_u.send(8'h4c, 1, 0);
		repeat (4001) @(posedge mclk);
		check({talker_r, n_dcl != 0}, 2'b01);
		ctl_u.mgmt(1, 0, 0, 0);
	endtask
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1;
		@(posedge mclk);
		check({dio_n_oe, dav_oe, nrfd_oe, ndac_oe, srq_oe, talker_r, listener_r}, 0);
		t_listen();
		t_talk();
		t_poll();
		t_ifc();
		summarize();
	end
endmodule // tb
